// *** hw/amp_responder_end.sv ***
`timescale 1ns/1ps
// Behaviour
// - frames sent untagged, never vlan tagged
// - destination is slow-protocol group address
// - source is the sending port's address
// - type field always slow-protocol type
// - subtype octet is 0x02
// - version octet sent as 0x01
// - tuple code 0x01 marker, 0x02 response
// - info tuple length is 16
// - initiator port number as unsigned integer
// - fixed octet layout, 124 octets plus check
// - whole octets, numeric fields msb first
// - bit 0 first on line, binary
// - marker answered on same link
// - markers queued as ordinary frames
// - flow control pauses markers too
// - collecting and distributing enables ignored
// - responder always present, initiator optional
// - initiator times out missing responses
// - response echoes port, system, tag
// - pad and reserved sent as zeros
// - version, pad, reserved never checked
module amp_responder_end (
   input wire logic clk,
   input wire logic resetn,
   amp_link_if.dev link,
   input wire logic [amp_pkg::MAC_W-1:0] port_mac,
   input wire logic cl_tx_valid,
   input wire logic [amp_pkg::OCT_W-1:0] cl_tx_data,
   input wire logic cl_tx_last,
   output logic cl_tx_ready,
   output logic cl_rx_valid,
   output logic [amp_pkg::OCT_W-1:0] cl_rx_data,
   output logic cl_rx_last,
   output logic marker_seen,
   output logic response_sent
);
   import amp_pkg::*;

   localparam int LOOK = int'(OFS_CODE) + 1;

   logic rx_take;
   logic [IDX_W-1:0] rx_idx;
   logic rx_par;
   logic hdr_ok;
   logic hdr_match;
   logic mk_now;
   logic mk_end;
   logic drop [2];
   logic [PORT_W-1:0] cap_port;
   logic [MAC_W-1:0] cap_sys;
   logic [TAG_W-1:0] cap_tag;
   logic resp_pend;
   logic [PORT_W-1:0] hold_port;
   logic [MAC_W-1:0] hold_sys;
   logic [TAG_W-1:0] hold_tag;
   amp_oct_type dl [LOOK];
   amp_oct_type dl_src [LOOK];
   amp_oct_type dl_out;
   logic tail_pending;
   logic shift;
   amp_tx_state_type st;
   logic turn_resp;
   logic resp_go;
   logic cl_go;
   logic b_valid;
   logic [7:0] b_data;
   logic b_last;
   logic b_ready;

   ////////////////////////////////////////////////////////////////////////
   // receive side never stalls the partner's sender
   assign link.par_tx_ready = 1'b1;
   assign rx_take = link.par_tx_valid;

   // version, pad and reserved never judged
   always_comb begin
      case (rx_idx)
         OFS_TYPE: hdr_match = (link.par_tx_data == SLOW_PROTO_TYPE[15:8]);
         OFS_TYPE_LO: hdr_match = (link.par_tx_data == SLOW_PROTO_TYPE[7:0]);
         OFS_SUBTYPE: hdr_match = (link.par_tx_data == SUBTYPE_MARKER);
         OFS_CODE: hdr_match = (link.par_tx_data == CODE_MARKER);
         default: hdr_match = 1'b1;
      endcase
   end

   assign mk_now = ((rx_idx == 7'h00) ? 1'b1 : hdr_ok) & hdr_match;
   assign mk_end = rx_take & link.par_tx_last & hdr_ok & (rx_idx >= OFS_PAD);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_idx <= 7'h00;
         rx_par <= 1'b0;
         hdr_ok <= 1'b0;
      end else if (rx_take) begin
         hdr_ok <= mk_now;
         if (link.par_tx_last) begin
            rx_idx <= 7'h00;
            rx_par <= ~rx_par;
         end else if (rx_idx != 7'h7F) begin
            rx_idx <= IDX_W'(rx_idx + 7'h01);
         end
      end
   end

   // one verdict per frame parity; frames ending before the code octet always pass
   always_ff @(posedge clk) begin
      if (!resetn) begin
         drop[0] <= 1'b0;
         drop[1] <= 1'b0;
      end else if (rx_take && rx_idx == 7'h00) begin
         drop[rx_par] <= 1'b0;
      end else if (rx_take && rx_idx == OFS_CODE) begin
         drop[rx_par] <= mk_now;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cap_port <= 16'h0000;
         cap_sys <= 48'h000000000000;
         cap_tag <= 32'h00000000;
      end else if (rx_take) begin
         if (rx_idx >= OFS_PORT && rx_idx < OFS_SYS)
            cap_port <= {cap_port[7:0], link.par_tx_data};
         if (rx_idx >= OFS_SYS && rx_idx < OFS_TAG)
            cap_sys <= {cap_sys[39:0], link.par_tx_data};
         if (rx_idx >= OFS_TAG && rx_idx < OFS_PAD)
            cap_tag <= {cap_tag[23:0], link.par_tx_data};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // look-ahead line: verdict known before a frame's first octet leaves;
   // tiny runts crowding it may take a stale verdict
   assign dl_out = dl[LOOK-1];

   always_comb begin
      tail_pending = 1'b0;
      for (int i = 0; i < LOOK; i++) begin
         tail_pending = tail_pending | (dl[i].valid & dl[i].last);
      end
   end

   assign shift = rx_take | tail_pending;

   generate
      for (genvar g = 0; g < LOOK; g++) begin : g_dl
         if (g == 0) begin : g_head
            assign dl_src[g] = '{valid: rx_take, last: link.par_tx_last,
                                 par: rx_par, data: link.par_tx_data};
         end else begin : g_body
            assign dl_src[g] = dl[g-1];
         end
         always_ff @(posedge clk) begin
            if (!resetn) begin
               dl[g] <= '0;
            end else if (shift) begin
               dl[g] <= dl_src[g];
            end
         end
      end
   endgenerate

   // delivered whatever the collecting state
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cl_rx_valid <= 1'b0;
         cl_rx_data <= 8'h00;
         cl_rx_last <= 1'b0;
      end else begin
         cl_rx_valid <= shift & dl_out.valid & ~drop[dl_out.par];
         cl_rx_data <= dl_out.data;
         cl_rx_last <= dl_out.last;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // one response slot: a marker that finds one owed is dropped,
   // so no stale answer goes out late
   always_ff @(posedge clk) begin
      if (!resetn) begin
         resp_pend <= 1'b0;
         hold_port <= 16'h0000;
         hold_sys <= 48'h000000000000;
         hold_tag <= 32'h00000000;
      end else if (mk_end && (!resp_pend || resp_go)) begin
         resp_pend <= 1'b1;
         hold_port <= cap_port;
         hold_sys <= cap_sys;
         hold_tag <= cap_tag;
      end else if (resp_go) begin
         resp_pend <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         marker_seen <= 1'b0;
         response_sent <= 1'b0;
      end else begin
         marker_seen <= mk_end;
         response_sent <= b_valid & b_ready & b_last;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit: whole frames, alternating when both wait; no precedence
   assign resp_go = (st == TX_IDLE) & resp_pend & (~cl_tx_valid | turn_resp);
   assign cl_go = (st == TX_IDLE) & cl_tx_valid & ~resp_go;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st <= TX_IDLE;
         turn_resp <= 1'b0;
      end else begin
         case (st)
            TX_IDLE: begin
               if (resp_go) st <= TX_RESP;
               else if (cl_go) st <= TX_CLIENT;
            end
            TX_CLIENT: begin
               if (cl_tx_valid && link.dev_tx_ready && cl_tx_last) begin
                  st <= TX_IDLE;
                  turn_resp <= 1'b1;
               end
            end
            TX_RESP: begin
               if (b_valid && b_ready && b_last) begin
                  st <= TX_IDLE;
                  turn_resp <= 1'b0;
               end
            end
            default: st <= TX_IDLE;
         endcase
      end
   end

   assign b_ready = (st == TX_RESP) & link.dev_tx_ready;
   assign cl_tx_ready = (st == TX_CLIENT) & link.dev_tx_ready;

   // octets go out whole; the mac puts bit 0 on the line first
   assign link.dev_tx_valid = (st == TX_CLIENT) ? cl_tx_valid :
                              (st == TX_RESP) ? b_valid : 1'b0;
   assign link.dev_tx_data = (st == TX_RESP) ? b_data : cl_tx_data;
   assign link.dev_tx_last = (st == TX_CLIENT) ? cl_tx_last :
                             (st == TX_RESP) ? b_last : 1'b0;

   amp_frame_builder u_builder (
      .clk(clk),
      .resetn(resetn),
      .start(resp_go),
      .kind(CODE_RESPONSE),
      .src_mac(port_mac),
      .port_id(hold_port),
      .sys_mac(hold_sys),
      .tag(hold_tag),
      .out_valid(b_valid),
      .out_data(b_data),
      .out_last(b_last),
      .out_ready(b_ready)
   );
endmodule

// *** hw/amp_pkg.sv ***
package amp_pkg;
   localparam int OCT_W = 8;
   localparam int MAC_W = 48;
   localparam int PORT_W = 16;
   localparam int TAG_W = 32;
   localparam int IDX_W = 7;

   localparam logic [47:0] SLOW_PROTO_GROUP_ADDR = 48'h0180C2000002;
   localparam logic [15:0] SLOW_PROTO_TYPE = 16'h8809;
   localparam logic [7:0] SUBTYPE_MARKER = 8'h02;
   localparam logic [7:0] VERSION_1 = 8'h01;
   localparam logic [7:0] CODE_MARKER = 8'h01;
   localparam logic [7:0] CODE_RESPONSE = 8'h02;
   localparam logic [7:0] INFO_TUPLE_LEN = 8'h10;
   localparam logic [7:0] CODE_TERM = 8'h00;
   localparam logic [7:0] END_TUPLE_LEN = 8'h00;

   // octet offsets within the frame, check sequence excluded
   localparam logic [6:0] OFS_SA = 7'h06;
   localparam logic [6:0] OFS_TYPE = 7'h0C;
   localparam logic [6:0] OFS_TYPE_LO = 7'h0D;
   localparam logic [6:0] OFS_SUBTYPE = 7'h0E;
   localparam logic [6:0] OFS_VERSION = 7'h0F;
   localparam logic [6:0] OFS_CODE = 7'h10;
   localparam logic [6:0] OFS_LEN = 7'h11;
   localparam logic [6:0] OFS_PORT = 7'h12;
   localparam logic [6:0] OFS_SYS = 7'h14;
   localparam logic [6:0] OFS_TAG = 7'h1A;
   localparam logic [6:0] OFS_PAD = 7'h1E;
   localparam logic [6:0] OFS_TERM = 7'h20;
   localparam logic [6:0] OFS_TERM_LEN = 7'h21;
   localparam logic [6:0] OFS_RSVD = 7'h22;
   localparam logic [6:0] FRAME_OCTETS = 7'h7C;

   localparam int CLK_MHZ = 250;
   localparam int RESP_WAIT_US = 1000;
   localparam int RESP_WAIT_CYCLES = RESP_WAIT_US * CLK_MHZ;

   typedef struct packed {
      logic valid;
      logic last;
      logic par;
      logic [7:0] data;
   } amp_oct_type;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_CLIENT = 2'b01,
      TX_RESP = 2'b11
   } amp_tx_state_type;

   typedef enum logic [1:0] {
      IN_IDLE = 2'b00,
      IN_SEND = 2'b01,
      IN_WAIT = 2'b11
   } amp_in_state_type;
endpackage

// *** hw/amp_link_if.sv ***
`timescale 1ns/1ps
interface amp_link_if;
   logic dev_tx_valid;
   logic [amp_pkg::OCT_W-1:0] dev_tx_data;
   logic dev_tx_last;
   logic dev_tx_ready;
   logic par_tx_valid;
   logic [amp_pkg::OCT_W-1:0] par_tx_data;
   logic par_tx_last;
   logic par_tx_ready;

   modport dev (
      output dev_tx_valid,
      output dev_tx_data,
      output dev_tx_last,
      input dev_tx_ready,
      input par_tx_valid,
      input par_tx_data,
      input par_tx_last,
      output par_tx_ready
   );

   modport par (
      input dev_tx_valid,
      input dev_tx_data,
      input dev_tx_last,
      output dev_tx_ready,
      output par_tx_valid,
      output par_tx_data,
      output par_tx_last,
      input par_tx_ready
   );
endinterface

// *** hw/amp_frame_builder.sv ***
`timescale 1ns/1ps
module amp_frame_builder (
   input wire logic clk,
   input wire logic resetn,
   input wire logic start,
   input wire logic [7:0] kind,
   input wire logic [amp_pkg::MAC_W-1:0] src_mac,
   input wire logic [amp_pkg::PORT_W-1:0] port_id,
   input wire logic [amp_pkg::MAC_W-1:0] sys_mac,
   input wire logic [amp_pkg::TAG_W-1:0] tag,
   output logic out_valid,
   output logic [7:0] out_data,
   output logic out_last,
   input wire logic out_ready
);
   import amp_pkg::*;

   logic [IDX_W-1:0] idx;
   logic [IDX_W-1:0] next_idx;
   logic [7:0] h_kind;
   logic [MAC_W-1:0] h_src;
   logic [PORT_W-1:0] h_port;
   logic [MAC_W-1:0] h_sys;
   logic [TAG_W-1:0] h_tag;

   function automatic logic [7:0] msb_oct(input logic [47:0] v,
                                          input int k, input int n);
      msb_oct = v[8*(n-1-k) +: 8];
   endfunction

   function automatic logic [7:0] octet_at(input logic [6:0] i,
      input logic [7:0] kd, input logic [47:0] sa, input logic [15:0] pt,
      input logic [47:0] sy, input logic [31:0] tg);
      int ii;
      logic [7:0] r;
      ii = int'(i);
      r = 8'h00;
      // never a tag between source and type
      if (ii < OFS_SA) r = msb_oct(SLOW_PROTO_GROUP_ADDR, ii, 6);
      else if (ii < OFS_TYPE) r = msb_oct(sa, ii - OFS_SA, 6);
      else if (ii < OFS_SUBTYPE)
         r = msb_oct({32'h00000000, SLOW_PROTO_TYPE}, ii - OFS_TYPE, 2);
      else if (ii == OFS_SUBTYPE) r = SUBTYPE_MARKER;
      else if (ii == OFS_VERSION) r = VERSION_1;
      else if (ii == OFS_CODE) r = kd;
      else if (ii == OFS_LEN) r = INFO_TUPLE_LEN;
      else if (ii < OFS_SYS)
         r = msb_oct({32'h00000000, pt}, ii - OFS_PORT, 2);
      else if (ii < OFS_TAG) r = msb_oct(sy, ii - OFS_SYS, 6);
      else if (ii < OFS_PAD) r = msb_oct({16'h0000, tg}, ii - OFS_TAG, 4);
      else if (ii == OFS_TERM) r = CODE_TERM;
      else if (ii == OFS_TERM_LEN) r = END_TUPLE_LEN;
      else r = 8'h00;
      octet_at = r;
   endfunction

   assign next_idx = IDX_W'(idx + 7'h01);

   ////////////////////////////////////////////////////////////////////////
   // fixed 124-octet layout; the mac appends the check sequence
   always_ff @(posedge clk) begin
      if (!resetn) begin
         out_valid <= 1'b0;
         out_data <= 8'h00;
         out_last <= 1'b0;
         idx <= 7'h00;
      end else if (!out_valid) begin
         if (start) begin
            out_valid <= 1'b1;
            idx <= 7'h00;
            out_last <= 1'b0;
            out_data <= octet_at(7'h00, kind, src_mac, port_id, sys_mac, tag);
         end
      end else if (out_ready) begin
         if (out_last) begin
            out_valid <= 1'b0;
            out_last <= 1'b0;
         end else begin
            idx <= next_idx;
            out_last <= (next_idx == IDX_W'(FRAME_OCTETS - 7'h01));
            out_data <= octet_at(next_idx, h_kind, h_src, h_port, h_sys, h_tag);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         h_kind <= 8'h00;
         h_src <= 48'h000000000000;
         h_port <= 16'h0000;
         h_sys <= 48'h000000000000;
         h_tag <= 32'h00000000;
      end else if (start && !out_valid) begin
         h_kind <= kind;
         h_src <= src_mac;
         h_port <= port_id;
         h_sys <= sys_mac;
         h_tag <= tag;
      end
   end
endmodule

// *** hw/amp_initiator_end.sv ***
`timescale 1ns/1ps
module amp_initiator_end #(
   parameter int RESP_WAIT_CYCLES = amp_pkg::RESP_WAIT_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   amp_link_if.par link,
   input wire logic [amp_pkg::MAC_W-1:0] own_mac,
   input wire logic req_valid,
   input wire logic [amp_pkg::PORT_W-1:0] req_port,
   input wire logic [amp_pkg::TAG_W-1:0] req_tag,
   output logic req_ready,
   output logic done_valid,
   output logic [amp_pkg::TAG_W-1:0] done_tag,
   output logic timed_out,
   output logic rx_valid,
   output logic [amp_pkg::OCT_W-1:0] rx_data,
   output logic rx_last
);
   import amp_pkg::*;

   generate
      if (RESP_WAIT_CYCLES < 1) begin : g_bad_wait
         $error("RESP_WAIT_CYCLES must be at least 1");
      end
   endgenerate

   amp_in_state_type st;
   logic [31:0] wait_cnt;
   logic [TAG_W-1:0] want_tag;
   logic [IDX_W-1:0] rx_idx;
   logic hdr_ok;
   logic hdr_match;
   logic [TAG_W-1:0] cap_tag;
   logic resp_end;
   logic b_valid;
   logic b_last;

   ////////////////////////////////////////////////////////////////////////
   assign link.dev_tx_ready = 1'b1;

   always_comb begin
      case (rx_idx)
         OFS_TYPE: hdr_match = (link.dev_tx_data == SLOW_PROTO_TYPE[15:8]);
         OFS_TYPE_LO: hdr_match = (link.dev_tx_data == SLOW_PROTO_TYPE[7:0]);
         OFS_SUBTYPE: hdr_match = (link.dev_tx_data == SUBTYPE_MARKER);
         OFS_CODE: hdr_match = (link.dev_tx_data == CODE_RESPONSE);
         default: hdr_match = 1'b1;
      endcase
   end

   assign resp_end = link.dev_tx_valid & link.dev_tx_last & hdr_ok &
                     (rx_idx >= OFS_PAD);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_idx <= 7'h00;
         hdr_ok <= 1'b0;
         cap_tag <= 32'h00000000;
      end else if (link.dev_tx_valid) begin
         hdr_ok <= ((rx_idx == 7'h00) ? 1'b1 : hdr_ok) & hdr_match;
         if (rx_idx >= OFS_TAG && rx_idx < OFS_PAD)
            cap_tag <= {cap_tag[23:0], link.dev_tx_data};
         if (link.dev_tx_last) rx_idx <= 7'h00;
         else if (rx_idx != 7'h7F) rx_idx <= IDX_W'(rx_idx + 7'h01);
      end
   end

   // every received octet is handed on
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
         rx_last <= 1'b0;
      end else begin
         rx_valid <= link.dev_tx_valid;
         rx_data <= link.dev_tx_data;
         rx_last <= link.dev_tx_last;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // a lost response must not hang the requester
   assign req_ready = (st == IN_IDLE);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st <= IN_IDLE;
         wait_cnt <= 32'h00000000;
         want_tag <= 32'h00000000;
         done_valid <= 1'b0;
         done_tag <= 32'h00000000;
         timed_out <= 1'b0;
      end else begin
         done_valid <= 1'b0;
         timed_out <= 1'b0;
         case (st)
            IN_IDLE: begin
               if (req_valid) begin
                  st <= IN_SEND;
                  want_tag <= req_tag;
               end
            end
            IN_SEND: begin
               if (b_valid && link.par_tx_ready && b_last) begin
                  st <= IN_WAIT;
                  wait_cnt <= 32'(RESP_WAIT_CYCLES - 1);
               end
            end
            IN_WAIT: begin
               if (resp_end && cap_tag == want_tag) begin
                  st <= IN_IDLE;
                  done_valid <= 1'b1;
                  done_tag <= cap_tag;
               end else if (wait_cnt == 32'h00000000) begin
                  st <= IN_IDLE;
                  timed_out <= 1'b1;
               end else begin
                  wait_cnt <= 32'(wait_cnt - 32'h00000001);
               end
            end
            default: st <= IN_IDLE;
         endcase
      end
   end

   assign link.par_tx_valid = b_valid;
   assign link.par_tx_last = b_last;

   amp_frame_builder u_builder (
      .clk(clk),
      .resetn(resetn),
      .start(req_valid && st == IN_IDLE),
      .kind(CODE_MARKER),
      .src_mac(own_mac),
      .port_id(req_port),
      .sys_mac(own_mac),
      .tag(req_tag),
      .out_valid(b_valid),
      .out_data(link.par_tx_data),
      .out_last(b_last),
      .out_ready(link.par_tx_ready)
   );
endmodule

// *** sim/amp_assertions.sv ***
`timescale 1ns/1ps
module amp_assertions (
   input wire logic clk,
   input wire logic resetn,
   input wire logic dev_tx_valid,
   input wire logic [amp_pkg::OCT_W-1:0] dev_tx_data,
   input wire logic dev_tx_last,
   input wire logic dev_tx_ready,
   input wire logic par_tx_valid,
   input wire logic [amp_pkg::OCT_W-1:0] par_tx_data,
   input wire logic par_tx_last,
   input wire logic par_tx_ready
);
   import amp_pkg::*;
   logic [6:0] pcnt;
   logic [6:0] dcnt;
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (!resetn)
         pcnt <= 7'h00;
      else if (par_tx_valid && par_tx_ready)
         pcnt <= par_tx_last ? 7'h00 : pcnt + 7'h01;
   end
   always_ff @(posedge clk) begin
      if (!resetn)
         dcnt <= 7'h00;
      else if (dev_tx_valid && dev_tx_ready)
         dcnt <= dev_tx_last ? 7'h00 : dcnt + 7'h01;
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence s_par(int k);
      par_tx_valid && pcnt == k;
   endsequence
   sequence s_marker_end;
      par_tx_valid && par_tx_ready && par_tx_last;
   endsequence
   // a response frame is the one with the response code at the code slot
   sequence s_resp_code;
      dev_tx_valid && dcnt == OFS_CODE && dev_tx_data == CODE_RESPONSE;
   endsequence
   a_par_frame_len:
      assert property (s_marker_end |-> pcnt == FRAME_OCTETS - 7'h01)
      else $error("marker frame length wrong");
   a_par_dest_addr:
      assert property (par_tx_valid && pcnt < OFS_SA |->
         par_tx_data == SLOW_PROTO_GROUP_ADDR[47 - 8 * pcnt -: 8])
      else $error("marker destination octet wrong");
   a_par_type_field:
      assert property (s_par(OFS_TYPE) |-> par_tx_data ==
         SLOW_PROTO_TYPE[15:8] ##1 par_tx_data == SLOW_PROTO_TYPE[7:0])
      else $error("marker type field wrong");
   a_par_subtype:
      assert property (s_par(OFS_SUBTYPE) |-> par_tx_data == SUBTYPE_MARKER)
      else $error("marker subtype wrong");
   a_par_version:
      assert property (s_par(OFS_VERSION) |-> par_tx_data == VERSION_1)
      else $error("marker version wrong");
   a_par_code:
      assert property (s_par(OFS_CODE) |-> par_tx_data == CODE_MARKER)
      else $error("marker tuple code wrong");
   a_par_info_len:
      assert property (s_par(OFS_LEN) |-> par_tx_data == INFO_TUPLE_LEN)
      else $error("marker tuple length wrong");
   a_par_zero_tail:
      assert property (par_tx_valid && pcnt >= OFS_PAD |-> par_tx_data == 8'h00)
      else $error("marker tail not zero");
   a_marker_answered:
      assert property (s_marker_end |-> ##[2:300] s_resp_code)
      else $error("marker not answered on the link");
   a_resp_zero_tail:
      assert property (dev_tx_valid && dcnt >= OFS_PAD |-> dev_tx_data == 8'h00)
      else $error("response tail not zero");
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import amp_pkg::*;
   // must outlast a response frame
   localparam int WAIT = 160;
   localparam logic [47:0] PMAC = 48'h0A1B2C3D4E5F;
   localparam logic [47:0] OMAC = 48'h02F0E1D2C3B4;
   logic clk;
   logic resetn;
   logic mute_n;
   logic cl_tx_valid;
   logic [7:0] cl_tx_data;
   logic cl_tx_last;
   logic cl_tx_ready;
   logic req_valid;
   logic [15:0] req_port;
   logic [31:0] req_tag;
   logic req_ready;
   logic done_valid;
   logic [31:0] done_tag;
   logic timed_out;
   logic response_sent;
   logic rx2_valid;
   logic [7:0] dq[$];
   logic [7:0] pq[$];
   logic [7:0] d2[$];
   int rx2_n;
   int rs_n;
   time last_t;
   int fail_count;
   int samples_checked;
   amp_link_if lk();
   amp_link_if lk2();
   ////////////////////////////////////////////////////////////////////////
   amp_responder_end i_amp_responder_end (.clk(clk),
      .resetn(resetn && mute_n), .link(lk.dev), .port_mac(PMAC),
      .cl_tx_valid(cl_tx_valid), .cl_tx_data(cl_tx_data),
      .cl_tx_last(cl_tx_last), .cl_tx_ready(cl_tx_ready), .cl_rx_valid(),
      .cl_rx_data(), .cl_rx_last(), .marker_seen(),
      .response_sent(response_sent));
   amp_responder_end i_amp_responder_end_b (.clk(clk), .resetn(resetn),
      .link(lk2.dev), .port_mac(PMAC), .cl_tx_valid(cl_tx_valid),
      .cl_tx_data(cl_tx_data), .cl_tx_last(cl_tx_last), .cl_tx_ready(),
      .cl_rx_valid(rx2_valid), .cl_rx_data(), .cl_rx_last(),
      .marker_seen(), .response_sent());
   amp_initiator_end #(.RESP_WAIT_CYCLES(WAIT)) i_amp_initiator_end (
      .clk(clk), .resetn(resetn), .link(lk.par), .own_mac(OMAC),
      .req_valid(req_valid), .req_port(req_port), .req_tag(req_tag),
      .req_ready(req_ready), .done_valid(done_valid), .done_tag(done_tag),
      .timed_out(timed_out), .rx_valid(), .rx_data(), .rx_last());
   amp_assertions i_amp_assertions (.clk(clk), .resetn(resetn && mute_n),
      .dev_tx_valid(lk.dev_tx_valid), .dev_tx_data(lk.dev_tx_data),
      .dev_tx_last(lk.dev_tx_last), .dev_tx_ready(lk.dev_tx_ready),
      .par_tx_valid(lk.par_tx_valid), .par_tx_data(lk.par_tx_data),
      .par_tx_last(lk.par_tx_last), .par_tx_ready(lk.par_tx_ready));
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (lk.dev_tx_valid && lk.dev_tx_ready) dq.push_back(lk.dev_tx_data);
      if (lk.par_tx_valid && lk.par_tx_ready) pq.push_back(lk.par_tx_data);
      if (lk.par_tx_valid && lk.par_tx_last) last_t = $time;
      if (lk2.dev_tx_valid) d2.push_back(lk2.dev_tx_data);
      if (rx2_valid) rx2_n++;
      if (response_sent) rs_n++;
   end
   function automatic logic [7:0] oct(int k, logic [7:0] kd,
      logic [47:0] sa, logic [15:0] pt, logic [31:0] tg);
      logic [271:0] h;
      h = {SLOW_PROTO_GROUP_ADDR, sa, SLOW_PROTO_TYPE, SUBTYPE_MARKER,
         VERSION_1, kd, INFO_TUPLE_LEN, pt, OMAC, tg, 16'h0000,
         CODE_TERM, END_TUPLE_LEN};
      return (k < 34) ? h[271 - 8 * k -: 8] : 8'h00;
   endfunction
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   task automatic wait_end;
      for (int n = 0; n < 400 && (done_valid | timed_out) !== 1'b1; n++)
         tick;
   endtask
   task automatic cmp_frame(ref logic [7:0] q[$], input logic [7:0] kd,
      input logic [47:0] sa, input logic [15:0] pt, input logic [31:0] tg);
      check(q.size(), FRAME_OCTETS);
      for (int k = 0; k < 124; k++)
         check(q[k], oct(k, kd, sa, pt, tg));
   endtask
   task automatic request(logic [15:0] pt, logic [31:0] tg);
      req_port = pt;
      req_tag = tg;
      req_valid = 1'b1;
      tick;
      req_valid = 1'b0;
   endtask
   task automatic t_marker;
      dq.delete();
      pq.delete();
      rs_n = 0;
      request(16'hA5C3, 32'h89ABCDEF);
      check(req_ready, 32'h0);
      // busy: a second request is ignored
      req_tag = 32'h00000001;
      req_valid = 1'b1;
      repeat (4) tick;
      req_valid = 1'b0;
      wait_end;
      check(done_tag, 32'h89ABCDEF);
      cmp_frame(pq, CODE_MARKER, OMAC, 16'hA5C3, 32'h89ABCDEF);
      cmp_frame(dq, CODE_RESPONSE, PMAC, 16'hA5C3, 32'h89ABCDEF);
      tick;
      check(rs_n, 32'h1);
   endtask
   task automatic t_client;
      logic r;
      int n;
      dq.delete();
      for (int i = 0; i < 8; i++) begin
         cl_tx_valid = 1'b1;
         cl_tx_data = 8'hC0 + 8'(i);
         cl_tx_last = (i == 7);
         n = 0;
         do begin
            r = cl_tx_ready;
            tick;
            n++;
         end while (r !== 1'b1 && n < 50);
      end
      cl_tx_valid = 1'b0;
      cl_tx_data = ~cl_tx_data;
      check(dq.size(), 32'h8);
      for (int i = 0; i < 8; i++)
         check(dq[i], 32'hC0 + i);
   endtask
   task automatic t_timeout;
      mute_n = 1'b0;
      request(16'h0001, 32'h00000002);
      wait_end;
      check(timed_out, 32'h1);
      check(32'(($time - 1 - last_t) / 4), WAIT);
      repeat (3) tick;
      mute_n = 1'b1;
      tick;
   endtask
   task automatic send2(logic [7:0] kd, logic [7:0] ver);
      d2.delete();
      rx2_n = 0;
      for (int k = 0; k < 124; k++) begin
         lk2.par_tx_valid = 1'b1;
         lk2.par_tx_data = (k == 15) ? ver : (k == 30) ? 8'hFF :
            oct(k, kd, PMAC, 16'h7E01, 32'h5A5A0F0F);
         lk2.par_tx_last = (k == 123);
         tick;
      end
      lk2.par_tx_valid = 1'b0;
      lk2.par_tx_data = ~lk2.par_tx_data;
      repeat (200) tick;
   endtask
   task automatic t_inject;
      send2(8'h03, VERSION_1);
      check(rx2_n, 32'h7C);
      check(d2.size(), 32'h0);
      send2(CODE_MARKER, 8'h07);
      check(rx2_n, 32'h0);
      cmp_frame(d2, CODE_RESPONSE, PMAC, 16'h7E01, 32'h5A5A0F0F);
   endtask
   task automatic complete_run;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #20000;
      fail_count++;
      complete_run;
   end
   initial begin
      resetn = 1'b0;
      mute_n = 1'b1;
      cl_tx_valid = 1'b0;
      cl_tx_data = 8'h00;
      cl_tx_last = 1'b0;
      req_valid = 1'b0;
      req_port = 16'h0000;
      req_tag = 32'h00000000;
      lk2.par_tx_valid = 1'b0;
      lk2.par_tx_data = 8'h00;
      lk2.par_tx_last = 1'b0;
      lk2.dev_tx_ready = 1'b1;
      repeat (2) @(posedge clk);
      #1 resetn = 1'b1;
      t_marker;
      t_client;
      t_timeout;
      t_inject;
      complete_run;
   end
endmodule
